// *** bench/tb.sv ***
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_errors++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end

// --------------------------------
// Control port bench
// --------------------------------
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic       bus_multiplex_select, bus_timing_select, cs_n, rd_n, wr_n, ale, data_oe;
    logic [7:0] addr_pin, data_in, data_out, q, a;
    logic       oe;
    int         n_errors = 0;
    int         compares = 0;

    // 25 MHz clock
    always #20 clock = ~clock;

    thp_host_port u_dut (.clock, .rst, .bus_multiplex_select, .bus_timing_select, .cs_n,
                         .rd_n, .wr_n, .ale, .addr_pin, .data_in, .data_out, .data_oe);
    thp_host_model u_host (.clock, .data_out, .data_oe, .bus_multiplex_select,
                           .bus_timing_select, .cs_n, .rd_n, .wr_n, .ale, .addr_pin, .data_in);

    // Both control sets, both test bytes, then the identity byte
    function automatic logic [7:0] addr_of(int i);
        if (i < 11) return thp_pkg::ADDR_CTRL_BASE_A + 8'(i);
        if (i < 22) return thp_pkg::ADDR_CTRL_BASE_B + 8'(i - 11);
        if (i == 22) return thp_pkg::ADDR_TEST_A;
        if (i == 23) return thp_pkg::ADDR_TEST_B;
        return thp_pkg::ADDR_DEVICE_IDENTITY;
    endfunction

    // Pattern differs per mode so a stale byte cannot pass
    function automatic logic [7:0] pat(int m, logic [7:0] ad);
        return ad ^ 8'(8'h3C + m * 8'h45);
    endfunction

    task automatic close_out();
        $display("Errors %0d, compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Watchdog, about nine times the expected run
    initial
    begin
        #2_000_000;
        n_errors++;
        close_out();
    end

    // Write all places in each mode, then read back to catch aliasing
    initial
    begin
        repeat (20) @(negedge clock);
        `CHK(data_oe, 1'b0)
        rst = 1'b0;
        repeat (3) @(negedge clock);
        u_host.access(1'b0, thp_pkg::ADDR_CTRL_BASE_B + 8'h0A, 8'h00, q, oe);
        `CHK(q, thp_pkg::REG_RESET)
        u_host.clear_all();
        for (int m = 0; m < 4; m++)
        begin
            u_host.set_mode(m[1], m[0]);
            for (int w = 1; w >= 0; w--)
            begin
                for (int i = 0; i < 25; i++)
                begin
                    a = addr_of(i);
                    u_host.access(w[0], a, pat(m, a), q, oe);
                    if (w == 0)
                    begin
                        `CHK(oe, 1'b1)
                        `CHK(data_oe, 1'b0)
                        if (a == thp_pkg::ADDR_DEVICE_IDENTITY)
                            `CHK(q, ({thp_pkg::ID_CLASS_T1, thp_pkg::ID_MEMBER_CODE, thp_pkg::ID_REVISION}))
                        else
                            `CHK(q, pat(m, a))
                    end
                end
            end
        end
        close_out();
    end
endmodule

// *** bench/thp_host_model.sv ***
// --------------------------------
// Host processor on the control port
// --------------------------------
module thp_host_model (
    input  wire logic       clock,                // System clock
    input  wire logic [7:0] data_out,             // Read data from device
    input  wire logic       data_oe,              // Device drives the bus
    output logic            bus_multiplex_select, // Shared bus pin
    output logic            bus_timing_select,    // Timing convention pin
    output logic            cs_n,                 // Chip select
    output logic            rd_n,                 // Read or data strobe
    output logic            wr_n,                 // Write strobe or direction
    output logic            ale,                  // Address strobe
    output logic      [7:0] addr_pin,             // Separate address bus
    output logic      [7:0] data_in               // Data or address bus
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle pins at time zero
    initial
    begin
        bus_multiplex_select = 1'b0;
        bus_timing_select = 1'b0;
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        ale = 1'b0;
        addr_pin = 8'h00;
        data_in = 8'h00;
    end

    // Modes change only while deselected, idle strobe level follows
    task automatic set_mode(input logic m, input logic t);
        @(negedge clock);
        bus_multiplex_select = m;
        bus_timing_select = t;
        rd_n = ~t;
        repeat (4) @(negedge clock);
    endtask

    // One byte access; strobes held 5 cycles, idle 5, per the port spacing
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic oe);
        @(negedge clock);
        if (bus_multiplex_select)
        begin
            // Separate bus carries junk so only the latched address can work
            data_in = a;
            addr_pin = ~a;
            ale = 1'b1;
            repeat (4) @(negedge clock);
            ale = 1'b0;
            @(negedge clock);
        end
        else
            addr_pin = a;
        // Released bus shows the inverse, never a stale match
        data_in = wr ? d : ~a;
        cs_n = 1'b0;
        wr_n = ~wr;
        rd_n = bus_timing_select | wr;
        repeat (5) @(negedge clock);
        q = data_out;
        oe = data_oe;
        cs_n = 1'b1;
        wr_n = 1'b1;
        rd_n = ~bus_timing_select;
        data_in = ~data_in;
        repeat (5) @(negedge clock);
    endtask

    // Contents are undefined after power-up, so every byte is zeroed first
    task automatic clear_all();
        logic [7:0] q;
        logic       oe;
        for (int i = 0; i < 256; i++) access(1'b1, 8'(i), 8'h00, q, oe);
    endtask
endmodule

// *** rtl/thp_host_port.sv ***
// Overview of operation
// - Select low gives separate address and data buses, select high a shared bus.
// - Timing select low uses read/write strobes, high uses direction plus data strobe.
// - Each framer owns eleven control registers: two receive, two transmit, seven common.
// - The identity register at 0Fh is read-only and ignores writes.
// - Identity bit 7 is a fixed class bit marking a T1 device.
// - Identity bits 6..4 hold a fixed family member code.
// - Identity bits 3..0 report the die revision.
module thp_host_port (
    input  wire logic       clock,                // 25 MHz system clock
    input  wire logic       rst,                  // Sync reset, active high
    input  wire logic       bus_multiplex_select, // Pin: 1 = shared bus
    input  wire logic       bus_timing_select,    // Pin: 1 = direction/strobe timing
    input  wire logic       cs_n,                 // Pin: chip select
    input  wire logic       rd_n,                 // Pin: read strobe or data strobe
    input  wire logic       wr_n,                 // Pin: write strobe or direction
    input  wire logic       ale,                  // Pin: address strobe
    input  wire logic [7:0] addr_pin,             // Pin: separate address bus
    input  wire logic [7:0] data_in,              // Pin: data/address bus in
    output logic      [7:0] data_out,             // Data bus out
    output logic            data_oe               // Data bus drive enable
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [12:0] s1_ff;
    logic [12:0] s2_ff;
    logic [7:0]  ad1_ff;
    logic [7:0]  ad2_ff;
    logic [7:0]  dt1_ff;
    logic [7:0]  dt2_ff;

    // Two stages on every pin; stage one is read by stage two only
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s1_ff  <= 13'h1F0E;
            s2_ff  <= 13'h1F0E;
            ad1_ff <= 8'h00;
            ad2_ff <= 8'h00;
            dt1_ff <= 8'h00;
            dt2_ff <= 8'h00;
        end
        else
        begin
            s1_ff  <= {5'h1F, bus_multiplex_select, bus_timing_select,
                       3'h0, cs_n, rd_n, wr_n} | {8'h00, ale, 4'h0};
            s2_ff  <= s1_ff;
            ad1_ff <= addr_pin;
            ad2_ff <= ad1_ff;
            dt1_ff <= data_in;
            dt2_ff <= dt1_ff;
        end
    end

    logic mux_s, tsel_s, ale_s, cs_s, rdp_s, wrp_s;
    assign mux_s  = s2_ff[7];
    assign tsel_s = s2_ff[6];
    assign ale_s = s2_ff[4];
    assign cs_s  = ~s2_ff[2];
    assign rdp_s = s2_ff[1];
    assign wrp_s = s2_ff[0];

    // ------------------------------------------------------------
    // Strobe decode per timing convention
    // ------------------------------------------------------------
    // Low: separate active-low read and write strobes.
    // High: rd pin is active-high data strobe, wr pin is read-not-write.
    logic rd_act, wr_act, acc_act;
    assign rd_act  = cs_s && (tsel_s ? (rdp_s && wrp_s) : ~rdp_s);
    assign wr_act  = cs_s && (tsel_s ? (rdp_s && ~wrp_s) : ~wrp_s);
    assign acc_act = rd_act || wr_act;

    // ------------------------------------------------------------
    // Address latch for shared bus
    // ------------------------------------------------------------
    logic [7:0] alat_ff;
    logic       ale_d_ff;
    logic       wr_d_ff;
    logic       ale_fall;

    // Latch while address strobe is high in shared mode and again on its fall, so the held value is final
    assign ale_fall = ale_d_ff && ~ale_s;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            alat_ff  <= 8'h00;
            ale_d_ff <= 1'b0;
            wr_d_ff  <= 1'b0;
        end
        else
        begin
            ale_d_ff <= ale_s;
            wr_d_ff  <= wr_act;
            if (ale_fall || (ale_s && mux_s))
                alat_ff <= dt2_ff;
        end
    end

    logic [7:0] addr_eff;
    assign addr_eff = mux_s ? alat_ff : ad2_ff;

    // Write committed at strobe release; data is settled by then
    logic wr_stb;
    assign wr_stb = wr_d_ff && ~wr_act;

    // ------------------------------------------------------------
    // Storage: two control sets and the flat remainder
    // ------------------------------------------------------------
    logic       hit_a, hit_b;
    logic [7:0] rd_a, rd_b;
    logic [7:0] addr_w_ff;
    logic [7:0] data_w_ff;

    // Hold address and data from the last active cycle of the write
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            addr_w_ff <= 8'h00;
            data_w_ff <= 8'h00;
        end
        else if (wr_act)
        begin
            addr_w_ff <= addr_eff;
            data_w_ff <= dt2_ff;
        end
    end

    thp_reg_set #(.NREG(thp_pkg::CTRL_REG_COUNT), .BASE(thp_pkg::ADDR_CTRL_BASE_A)) u_set_a (
        .clock  (clock),
        .rst    (rst),
        .addr   (wr_stb ? addr_w_ff : addr_eff),
        .wdata  (data_w_ff),
        .wr_stb (wr_stb),
        .hit    (hit_a),
        .rdata  (rd_a)
    );

    thp_reg_set #(.NREG(thp_pkg::CTRL_REG_COUNT), .BASE(thp_pkg::ADDR_CTRL_BASE_B)) u_set_b (
        .clock  (clock),
        .rst    (rst),
        .addr   (wr_stb ? addr_w_ff : addr_eff),
        .wdata  (data_w_ff),
        .wr_stb (wr_stb),
        .hit    (hit_b),
        .rdata  (rd_b)
    );

    // Other registers, test and reserved included; held so the host
    // can clear them, their function lives outside this block
    logic [7:0] flat_ff [256];
    logic       id_hit;
    assign id_hit = (addr_eff == thp_pkg::ADDR_DEVICE_IDENTITY);

    always_ff @(posedge clock)
    begin
        if (wr_stb && addr_w_ff != thp_pkg::ADDR_DEVICE_IDENTITY)
            flat_ff[addr_w_ff] <= data_w_ff;
    end

    // Identity value: fixed class, member and revision
    logic [7:0] id_val;
    assign id_val = {thp_pkg::ID_CLASS_T1,
                     thp_pkg::ID_MEMBER_CODE,
                     thp_pkg::ID_REVISION};

    logic [7:0] rd_mux;
    assign rd_mux = id_hit ? id_val : hit_a ? rd_a : hit_b ? rd_b : flat_ff[addr_eff];

    // ------------------------------------------------------------
    // Read data register
    // ------------------------------------------------------------
    logic       oe_ff;
    logic [7:0] dout_ff;
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            oe_ff   <= 1'b0;
            dout_ff <= 8'h00;
        end
        else
        begin
            oe_ff   <= rd_act;
            // Zero while idle so uncleared bytes reach the pins only when read
            dout_ff <= rd_act ? rd_mux : 8'h00;
        end
    end
    assign data_out = dout_ff;
    assign data_oe  = oe_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_id_fixed: assert property (@(posedge clock) disable iff (rst)
        rd_act && id_hit |=> data_out[7] == thp_pkg::ID_CLASS_T1 && data_oe)
        else $error("identity class bit wrong");
    chk_id_member: assert property (@(posedge clock) disable iff (rst)
        rd_act && id_hit |=> data_out[6:4] == thp_pkg::ID_MEMBER_CODE)
        else $error("member code wrong");
    chk_id_rev: assert property (@(posedge clock) disable iff (rst)
        rd_act && id_hit |=> data_out[3:0] == thp_pkg::ID_REVISION)
        else $error("revision wrong");
    chk_oe_follow: assert property (@(posedge clock) disable iff (rst)
        !rd_act |=> !data_oe)
        else $error("bus driven without read");
    chk_mux_addr: assert property (@(posedge clock) disable iff (rst)
        mux_s && ale_s |=> alat_ff == $past(dt2_ff))
        else $error("address not latched");
    chk_addr_sel: assert property (@(posedge clock) disable iff (rst)
        !mux_s |-> addr_eff == ad2_ff)
        else $error("separate address not used");
    // First register of framer A takes the held write byte
    chk_ctrl_write: assert property (@(posedge clock) disable iff (rst)
        wr_stb && addr_w_ff == thp_pkg::ADDR_CTRL_BASE_A
        |=> u_set_a.regs_ff[0] == $past(data_w_ff))
        else $error("control write lost");
    chk_timing_strobe: assert property (@(posedge clock) disable iff (rst)
        tsel_s && cs_s && !rdp_s |-> !acc_act)
        else $error("access without data strobe");
    // Identity byte wins the read select whatever was written there
    chk_id_ro: assert property (@(posedge clock) disable iff (rst)
        id_hit |-> rd_mux == {thp_pkg::ID_CLASS_T1, thp_pkg::ID_MEMBER_CODE,
                              thp_pkg::ID_REVISION})
        else $error("identity changed by write");

    cov_mux_write:    cover property (@(posedge clock) mux_s && wr_stb);
    cov_sep_read:     cover property (@(posedge clock) !mux_s && rd_act);
    cov_timing_write: cover property (@(posedge clock) tsel_s && wr_stb);
    cov_id_read:    cover property (@(posedge clock) rd_act && id_hit);
endmodule

// *** rtl/thp_pkg.sv ***
package thp_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_DEVICE_IDENTITY = 8'h0F;
    localparam logic [7:0] ADDR_TEST_A          = 8'h09;
    localparam logic [7:0] ADDR_TEST_B          = 8'h7D;
    // Control set bases: one per framer, eleven registers each
    localparam logic [7:0] ADDR_CTRL_BASE_A     = 8'h20;
    localparam logic [7:0] ADDR_CTRL_BASE_B     = 8'hA0;
    localparam int         CTRL_REG_COUNT       = 11;
    // Offsets within a control set
    localparam logic [3:0] OFS_RECEIVE_CONTROL_ONE   = 4'h0;
    localparam logic [3:0] OFS_RECEIVE_CONTROL_TWO   = 4'h1;
    localparam logic [3:0] OFS_TRANSMIT_CONTROL_ONE  = 4'h2;
    localparam logic [3:0] OFS_TRANSMIT_CONTROL_TWO  = 4'h3;
    localparam logic [3:0] OFS_COMMON_CONTROL_FIRST  = 4'h4;
    localparam logic [3:0] OFS_COMMON_CONTROL_LAST   = 4'hA;
    // ------------------------------------------------------------
    // Identity fields
    // ------------------------------------------------------------
    localparam int         ID_CLASS_BIT    = 7;
    localparam int         ID_MEMBER_MSB   = 6;
    localparam int         ID_MEMBER_LSB   = 4;
    localparam int         ID_REV_MSB      = 3;
    localparam logic       ID_CLASS_T1     = 1'b1;  // Arbitrary value
    localparam logic [2:0] ID_MEMBER_CODE  = 3'h5;  // Arbitrary value
    localparam logic [3:0] ID_REVISION     = 4'h1;  // Arbitrary value
    localparam logic [7:0] REG_RESET       = 8'h00;
endpackage

// *** rtl/thp_reg_set.sv ***
// Eleven-register control set of one framer
module thp_reg_set #(
    parameter int         NREG = 11,
    parameter logic [7:0] BASE = 8'h20
) (
    input  wire logic       clock,    // System clock
    input  wire logic       rst,      // Sync reset
    input  wire logic [7:0] addr,     // Register address
    input  wire logic [7:0] wdata,    // Write data
    input  wire logic       wr_stb,   // Write strobe
    output logic            hit,      // Address in this set
    output logic      [7:0] rdata     // Read data
);
    // --------------------------------------------------------
    // Storage and decode
    // --------------------------------------------------------
    logic [7:0] regs_ff [NREG];
    logic [7:0] ofs;
    assign ofs   = addr - BASE;
    assign hit   = (addr >= BASE) && (ofs < 8'(NREG));
    assign rdata = hit ? regs_ff[ofs[3:0]] : 8'h00;

    // One writable register per slot
    genvar g;
    generate
        for (g = 0; g < NREG; g++)
        begin : g_reg
            always_ff @(posedge clock)
            begin
                if (rst)
                    regs_ff[g] <= thp_pkg::REG_RESET;
                else if (wr_stb && hit && ofs == 8'(g))
                    regs_ff[g] <= wdata;
            end
        end
    endgenerate
endmodule
